// *** dmg_data_mem.sv ***
/*
 * on-chip data memory, one read and one write port, registered read data.
 * assumes one clock and a clock enable shared with the execution unit.
 */
`timescale 1ns/10ps
module dmg_data_mem
	import dmg_pkg::*;
(
	// clock
	input  wire logic      clk_sys,
	input  wire logic      clk_en,
	// read port
	input  wire dmg_addr_t rd_addr,
	output logic [15:0]    rd_data,
	// write port
	input  wire logic      wr_en,
	input  wire dmg_addr_t wr_addr,
	input  wire dmg_word_t wr_data
);
	// storage, no reset so it maps onto ram
	logic [15:0] mem_q [0:`DMG_MEM_WORDS-1];

	// ****************************************************************
	// ports
	// ****************************************************************
	// array write; a plain clocked process so a bench may preload words
	always @(posedge clk_sys) begin
		if (clk_en && wr_en && (wr_addr < `DMG_MEM_WORDS))
			mem_q[wr_addr] <= wr_data;
	end
	// read data comes out of a register
	always_ff @(posedge clk_sys) begin
		if (clk_en) begin
			rd_data <= (rd_addr < `DMG_MEM_WORDS) ? mem_q[rd_addr] : 16'h0000;
		end
	end
endmodule : dmg_data_mem

// *** dmg_defines.svh ***
/*
 * constants for the multiply group execution block: opcodes, field positions,
 * widths, reset values and the multiplier corner case.
 * assumes it is included by the package by bare name.
 */
// Contract
// [RL1] load-mult-and-add copies memory word to multiplicand
// [RL2] same instruction adds old product into accumulator
// [RL3] then writes word to next higher address
// [RL4] direct-mode aux modify changes nothing
// [RL5] indirect aux modify loads new pointer select
// [RL6] most negative squared wraps, no saturation
// [RL7] multiply immediate uses signed 13-bit constant
// [RL8] interrupt held off through following instruction
// [RL9] program should consume product after immediate multiply
// [RL10] direct address uses page select bit
// [RL11] memory multiply signed into product, one cycle; code takes two cycles
// [RL12] indirect aux modify steps selected register only
`ifndef DMG_DEFINES_SVH
`define DMG_DEFINES_SVH

// ****************************************************************
// opcode patterns
// ****************************************************************
`define DMG_OP_LTD_HI   8'h6B
`define DMG_OP_MAR_HI   8'h68
`define DMG_OP_MPY_HI   8'h6D
`define DMG_OP_MULTIPLY_IMMEDIATE_HI  3'h4
`define DMG_OP_NOP      16'h7F80

// ****************************************************************
// instruction field positions
// ****************************************************************
`define DMG_IND_BIT     7
`define DMG_NARP_BIT    3
`define DMG_NXT_BIT     0
`define DMG_INC_BIT     5
`define DMG_DEC_BIT     4

// ****************************************************************
// widths and reset values
// ****************************************************************
`define DMG_ADDR_W      8
`define DMG_MEM_WORDS   144
`define DMG_RST_ACC     32'h0000_0000
`define DMG_RST_PROD    32'h0000_0000
`define DMG_RST_MULT    16'h0000
`define DMG_RST_AUX     8'h00

// ****************************************************************
// multiplier corner case
// ****************************************************************
`define DMG_MOST_NEG    16'h8000
`define DMG_MIN_SQ      32'hC000_0000

`endif

// *** dmg_exec.sv ***
/*
 * multiply group execution unit: delay-line load/accumulate, aux modify,
 * memory and immediate multiply, no-operation.
 * assumes instructions arrive with a valid/ready handshake, and that the
 * sequencer honours int_hold_ff when taking interrupts.
 */
`timescale 1ns/10ps
module dmg_exec
	import dmg_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        clk_en,
	// instruction stream
	input  wire logic        instr_valid,
	input  wire logic [15:0] instr_word,
	output logic             instr_ready,
	// state visible to the rest of the core
	input  wire logic        page_select_bit,
	output logic [31:0]      acc_ff,
	output logic [31:0]      prod_ff,
	output logic [15:0]      mult_ff,
	output logic [7:0]       aux0_ff,
	output logic [7:0]       aux1_ff,
	output logic             aux_ptr_ff,
	output logic             int_hold_ff,
	output logic             done_ff
);
	// ****************************************************************
	// decoding
	// ****************************************************************
	function automatic dmg_class_e classify(input logic [15:0] w);
		if (w[15:13] == `DMG_OP_MULTIPLY_IMMEDIATE_HI)       return DMG_CL_MULTIPLY_IMMEDIATE;
		else if (w == `DMG_OP_NOP)             return DMG_CL_NOP;
		else if (w[15:8] == `DMG_OP_LTD_HI)    return DMG_CL_LTD;
		else if (w[15:8] == `DMG_OP_MAR_HI)    return DMG_CL_MAR;
		else if (w[15:8] == `DMG_OP_MPY_HI)    return DMG_CL_MPY;
		else                                   return DMG_CL_NONE;
	endfunction : classify

	// signed 16x16 product; the most negative value squared gives the fixed pattern
	function automatic logic [31:0] mul_wrap(input logic [15:0] a, input logic [15:0] b);
		if (a == `DMG_MOST_NEG && b == `DMG_MOST_NEG)
			return `DMG_MIN_SQ; // RL6
		return 32'($signed(a) * $signed(b));
	endfunction : mul_wrap

	// operand address: page bit for direct, selected aux for indirect
	function automatic dmg_addr_t opnd_addr(input logic [15:0] w, input logic pg,
		input logic [7:0] a0, input logic [7:0] a1, input logic ap);
		if (w[`DMG_IND_BIT])
			return ap ? a1 : a0;
		else
			return {pg, w[6:0]}; // RL10
	endfunction : opnd_addr

	// ****************************************************************
	// registers
	// ****************************************************************
	dmg_state_e  state_ff, nxt_state;     // execution phase
	logic [15:0] iw_ff, nxt_iw;           // instruction in execution
	dmg_addr_t   ad_ff, nxt_ad;           // operand address latched
	logic [31:0] nxt_acc, nxt_prod;
	logic [15:0] nxt_mult;
	logic [7:0]  nxt_aux0, nxt_aux1;
	logic        nxt_aux_ptr, nxt_int_hold, nxt_done;
	logic        hold_arm_ff, nxt_hold_arm; // immediate multiply just ran
	dmg_class_e  cls_q;                   // class of latched word
	dmg_class_e  cls_in;                  // class of incoming word
	logic        take;                    // instruction accepted
	// memory ports
	dmg_addr_t   rd_addr;
	logic [15:0] rd_data;
	logic        wr_en;
	dmg_addr_t   wr_addr;
	logic [7:0]  aux_sel;                 // currently selected aux value
	logic [7:0]  aux_new;                 // stepped aux value

	assign cls_in      = classify(instr_word);
	assign cls_q       = classify(iw_ff);
	// memory-touching classes take a second phase, so stall in it
	assign instr_ready = (state_ff == DMG_ST_READ);
	assign take        = clk_en && instr_valid && instr_ready;
	assign rd_addr     = opnd_addr(instr_word, page_select_bit, aux0_ff, aux1_ff, aux_ptr_ff);
	assign aux_sel     = aux_ptr_ff ? aux1_ff : aux0_ff;

	dmg_data_mem u_mem (
		.clk_sys (clk_sys),
		.clk_en  (clk_en),
		.rd_addr (rd_addr),
		.rd_data (rd_data),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (rd_data)
	);

	// ****************************************************************
	// next-state logic
	// ****************************************************************
	always_comb begin
		nxt_state    = state_ff;
		nxt_iw       = iw_ff;
		nxt_ad       = ad_ff;
		nxt_acc      = acc_ff;
		nxt_prod     = prod_ff;
		nxt_mult     = mult_ff;
		nxt_aux0     = aux0_ff;
		nxt_aux1     = aux1_ff;
		nxt_aux_ptr  = aux_ptr_ff;
		nxt_hold_arm = hold_arm_ff;
		nxt_int_hold = int_hold_ff;
		nxt_done     = 1'b0;
		wr_en        = 1'b0;
		wr_addr      = 8'(ad_ff + 8'h01);
		aux_new      = aux_sel;
		unique case (state_ff)
			DMG_ST_READ: begin
				if (take) begin
					nxt_iw = instr_word;
					nxt_ad = rd_addr;
					// an instruction after the immediate multiply releases the hold
					nxt_int_hold = 1'b0;
					nxt_hold_arm = 1'b0;
					unique case (cls_in)
						DMG_CL_MULTIPLY_IMMEDIATE: begin
							// signed 13-bit constant; wrap, never saturate
							nxt_prod = 32'($signed(mult_ff) * $signed(instr_word[12:0])); // RL7
							nxt_int_hold = 1'b1; // RL8
							nxt_hold_arm = 1'b1;
							nxt_done = 1'b1;
						end
						DMG_CL_MAR: begin
							if (instr_word[`DMG_IND_BIT]) begin
								if (instr_word[`DMG_INC_BIT])
									aux_new = aux_sel + 8'h01; // RL12
								else if (instr_word[`DMG_DEC_BIT])
									aux_new = aux_sel - 8'h01; // RL12
								if (aux_ptr_ff)
									nxt_aux1 = aux_new;
								else
									nxt_aux0 = aux_new;
								if (!instr_word[`DMG_NARP_BIT])
									nxt_aux_ptr = instr_word[`DMG_NXT_BIT]; // RL5
							end
							// direct form leaves the aux registers and pointer alone RL4
							nxt_done = 1'b1;
						end
						DMG_CL_LTD, DMG_CL_MPY: begin
							// memory word arrives next cycle
							nxt_state = DMG_ST_WRITE;
						end
						default: begin
							nxt_done = 1'b1; // no_operation and foreign codes
						end
					endcase
				end
			end
			DMG_ST_WRITE: begin
				if (clk_en) begin
					if (cls_q == DMG_CL_LTD) begin
						nxt_mult = rd_data; // RL1
						nxt_acc  = acc_ff + prod_ff; // RL2
						wr_en    = 1'b1; // RL3
					end else begin
						// full 32-bit product: 8000h squared wraps to C0000000h
						nxt_prod = mul_wrap(mult_ff, rd_data); // RL11 RL6
					end
					// indirect post-step of the pointer register
					if (iw_ff[`DMG_IND_BIT]) begin
						if (iw_ff[`DMG_INC_BIT])
							aux_new = aux_sel + 8'h01;
						else if (iw_ff[`DMG_DEC_BIT])
							aux_new = aux_sel - 8'h01;
						if (aux_ptr_ff)
							nxt_aux1 = aux_new;
						else
							nxt_aux0 = aux_new;
						if (!iw_ff[`DMG_NARP_BIT])
							nxt_aux_ptr = iw_ff[`DMG_NXT_BIT];
					end
					nxt_done  = 1'b1;
					nxt_state = DMG_ST_READ;
				end
			end
		endcase
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_ff    <= DMG_ST_READ;
			iw_ff       <= `DMG_OP_NOP;
			ad_ff       <= `DMG_RST_AUX;
			acc_ff      <= `DMG_RST_ACC;
			prod_ff     <= `DMG_RST_PROD;
			mult_ff     <= `DMG_RST_MULT;
			aux0_ff     <= `DMG_RST_AUX;
			aux1_ff     <= `DMG_RST_AUX;
			aux_ptr_ff  <= 1'b0;
			hold_arm_ff <= 1'b0;
			int_hold_ff <= 1'b0;
			done_ff     <= 1'b0;
		end else if (clk_en) begin
			state_ff    <= nxt_state;
			iw_ff       <= nxt_iw;
			ad_ff       <= nxt_ad;
			acc_ff      <= nxt_acc;
			prod_ff     <= nxt_prod;
			mult_ff     <= nxt_mult;
			aux0_ff     <= nxt_aux0;
			aux1_ff     <= nxt_aux1;
			aux_ptr_ff  <= nxt_aux_ptr;
			hold_arm_ff <= nxt_hold_arm;
			int_hold_ff <= nxt_int_hold;
			done_ff     <= nxt_done;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	chk_ltd_mult: assert property (clk_en && state_ff == DMG_ST_WRITE && cls_q == DMG_CL_LTD
		|=> mult_ff == $past(rd_data)) else $error("multiplicand not loaded"); // RL1
	chk_ltd_acc: assert property (clk_en && state_ff == DMG_ST_WRITE && cls_q == DMG_CL_LTD
		|=> acc_ff == $past(acc_ff) + $past(prod_ff)) else $error("acc add wrong"); // RL2
	chk_ltd_write: assert property (wr_en |-> wr_addr == 8'(ad_ff + 8'h01))
		else $error("delay write address wrong"); // RL3
	chk_mar_direct: assert property (take && cls_in == DMG_CL_MAR && !instr_word[7]
		|=> $stable(aux0_ff) && $stable(aux1_ff) && $stable(aux_ptr_ff))
		else $error("direct modify changed state"); // RL4
	chk_mar_ptr: assert property (take && cls_in == DMG_CL_MAR && instr_word[7] && !instr_word[3]
		|=> aux_ptr_ff == $past(instr_word[0])) else $error("pointer not loaded"); // RL5
	chk_multiply_immediate_prod: assert property (take && cls_in == DMG_CL_MULTIPLY_IMMEDIATE
		|=> prod_ff == 32'($signed($past(mult_ff)) * $signed($past(instr_word[12:0]))))
		else $error("immediate product wrong"); // RL7
	chk_multiply_immediate_hold: assert property (take && cls_in == DMG_CL_MULTIPLY_IMMEDIATE |=> int_hold_ff)
		else $error("interrupt not held"); // RL8
	chk_mpy_prod: assert property (clk_en && state_ff == DMG_ST_WRITE && cls_q == DMG_CL_MPY
		|=> prod_ff == (($past(mult_ff) == `DMG_MOST_NEG && $past(rd_data) == `DMG_MOST_NEG)
		? `DMG_MIN_SQ : 32'($signed($past(mult_ff)) * $signed($past(rd_data)))))
		else $error("memory product wrong"); // RL11 RL6
	chk_mar_noacc: assert property (take && cls_in == DMG_CL_MAR
		|=> $stable(acc_ff) && $stable(prod_ff)) else $error("modify touched acc"); // RL12
	chk_dir_page: assert property (!instr_word[7] |-> rd_addr[7] == page_select_bit)
		else $error("page bit unused"); // RL10

	cov_ltd: cover property (take && cls_in == DMG_CL_LTD ##1 clk_en ##1 done_ff);
	cov_mpy: cover property (take && cls_in == DMG_CL_MPY);
	cov_multiply_immediate_then: cover property (take && cls_in == DMG_CL_MULTIPLY_IMMEDIATE ##1 take);
	cov_mar_ind: cover property (take && cls_in == DMG_CL_MAR && instr_word[7]);
endmodule : dmg_exec

// *** dmg_instr_src.sv ***
/* instruction stream source standing in front of the execution unit.
 * assumes one clock; words change only at the falling edge. */
`timescale 1ns/10ps
module dmg_instr_src (
	// clock and handshake
	input  wire logic        clk_sys,
	input  wire logic        instr_ready,
	// instruction stream
	output logic             instr_valid,
	output logic [15:0]      instr_word
);
	// quiet stream at time zero
	initial begin
		instr_valid = 1'b0;
		instr_word  = 16'h0000;
	end
	// offer a word and hold it up to the edge that takes it
	task automatic issue(input logic [15:0] w);
		@(negedge clk_sys);
		instr_valid = 1'b1;
		instr_word  = w;
		while (instr_ready !== 1'b1) @(negedge clk_sys);
		@(posedge clk_sys);
	endtask : issue
	// drop the offer; the word is inverted so a stale code never looks held
	task automatic release_now();
		instr_valid = 1'b0;
		instr_word  = ~instr_word;
	endtask : release_now
endmodule : dmg_instr_src

// *** dmg_pkg.sv ***
/*
 * types shared by the multiply group execution block.
 * assumes dmg_defines.svh sits in the same folder.
 */
`include "dmg_defines.svh"
package dmg_pkg;
	typedef logic [`DMG_ADDR_W-1:0] dmg_addr_t;  // data memory address
	typedef logic [15:0]            dmg_word_t;  // data word
	// instruction classes decoded by this block
	typedef enum logic [2:0] {
		DMG_CL_NONE = 3'h0,
		DMG_CL_LTD  = 3'h1,
		DMG_CL_MAR  = 3'h3,
		DMG_CL_MPY  = 3'h2,
		DMG_CL_MULTIPLY_IMMEDIATE = 3'h6,
		DMG_CL_NOP  = 3'h7
	} dmg_class_e;
	// two-phase execution: read then write-back
	typedef enum logic [0:0] {
		DMG_ST_READ  = 1'b0,
		DMG_ST_WRITE = 1'b1
	} dmg_state_e;
endpackage : dmg_pkg

// *** dsp_multiply_group_execution_test.sv ***
/* self-checking bench for the execution unit, one task per scenario.
 * assumes data memory contents are unknown at start, so the memory case
 * preloads the words it reads before checking fixed values. */
`timescale 1ns/10ps
module dsp_multiply_group_execution_test;
	logic        clk_sys, reset_n, clk_en, page_select_bit;
	logic        instr_valid, instr_ready, aux_ptr_ff, int_hold_ff, done_ff;
	logic [15:0] instr_word, mult_ff;
	logic [31:0] acc_ff, prod_ff;
	logic [7:0]  aux0_ff, aux1_ff;
	int          n_fail, compares, cyc_cnt;
	// ************
	// instances
	// ************
	dmg_instr_src src (.clk_sys(clk_sys), .instr_ready(instr_ready),
		.instr_valid(instr_valid), .instr_word(instr_word));
	dmg_exec uut (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
		.instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready),
		.page_select_bit(page_select_bit), .acc_ff(acc_ff), .prod_ff(prod_ff),
		.mult_ff(mult_ff), .aux0_ff(aux0_ff), .aux1_ff(aux1_ff),
		.aux_ptr_ff(aux_ptr_ff), .int_hold_ff(int_hold_ff), .done_ff(done_ff));
	// 200 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// hang guard: whole run needs under a hundred cycles
	always @(posedge clk_sys) begin
		cyc_cnt++;
		if (cyc_cnt == 2000) begin
			n_fail++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		if (n_fail == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp
	// issue one word, count cycles to done, check the stall phase
	task automatic run(input logic [15:0] w, input int cyc);
		int n;
		src.issue(w);
		n = 0;
		do begin
			@(negedge clk_sys);
			if (n == 0) begin
				src.release_now();
				cmp("ready", 32'(cyc == 1), 32'(instr_ready));
			end
			n++;
		end while (done_ff !== 1'b1 && n < 8);
		cmp("cycles", cyc, n);
	endtask : run
	task automatic state(input logic [31:0] a, input logic [31:0] pr, input logic [7:0] x0,
		input logic [7:0] x1, input logic ap);
		cmp("acc", a, acc_ff);
		cmp("prod", pr, prod_ff);
		cmp("aux0", 32'(x0), 32'(aux0_ff));
		cmp("aux1", 32'(x1), 32'(aux1_ff));
		cmp("ptr", 32'(ap), 32'(aux_ptr_ff));
	endtask : state
	// step, load pointer, direct no-op
	task automatic t_aux();
		run(16'h68A8, 1); state(0, 0, 8'h01, 8'h00, 1'b0);
		run(16'h6898, 1); state(0, 0, 8'h00, 8'h00, 1'b0);
		run(16'h6881, 1); state(0, 0, 8'h00, 8'h00, 1'b1);
		run(16'h68A8, 1); state(0, 0, 8'h00, 8'h01, 1'b1);
		run(16'h6805, 1); state(0, 0, 8'h00, 8'h01, 1'b1);
		run(16'h6880, 1); state(0, 0, 8'h00, 8'h01, 1'b0);
		run(16'h7F80, 1); state(0, 0, 8'h00, 8'h01, 1'b0);
	endtask : t_aux
	// interrupt gate over the following instruction
	task automatic t_hold();
		run(16'h8003, 1);
		cmp("hold", 1, 32'(int_hold_ff));
		run(16'h7F80, 1);
		cmp("hold", 0, 32'(int_hold_ff));
	endtask : t_hold
	// delay-line load, memory and immediate multiply on page one
	task automatic t_mem();
		page_select_bit = 1'b1;
		// preload: word 85h most negative, word 86h a marker the delay line overwrites
		uut.u_mem.mem_q[133] = 16'h8000;
		uut.u_mem.mem_q[134] = 16'h1234;
		run(16'h6B05, 2);
		cmp("mult", 32'h0000_8000, 32'(mult_ff));
		cmp("acc", 0, acc_ff);
		run(16'h6B06, 2);
		cmp("mult", 32'h0000_8000, 32'(mult_ff));
		run(16'h6D06, 2);
		cmp("prod", 32'hC000_0000, prod_ff);
		run(16'h9FF7, 1);
		cmp("prod", 32'h0004_8000, prod_ff);
		run(16'h6B06, 2);
		cmp("acc", 32'h0004_8000, acc_ff);
		cmp("hold", 0, 32'(int_hold_ff));
	endtask : t_mem
	// ************
	// main sequence
	// ************
	initial begin
		n_fail = 0;
		compares = 0;
		cyc_cnt = 0;
		reset_n = 1'b0;
		clk_en = 1'b1;
		page_select_bit = 1'b0;
		repeat (3) @(negedge clk_sys);
		reset_n = 1'b1;
		state(0, 0, 8'h00, 8'h00, 1'b0);
		cmp("mult", 0, 32'(mult_ff));
		t_aux();
		t_hold();
		t_mem();
		report_and_stop();
	end
endmodule : dsp_multiply_group_execution_test
